// File: core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire irq_logic_pkg::core_cmd_t core_cmd,
   input wire logic wake_req,
   input wire logic sleep_go,
   input wire logic reti_go,
   output logic core_sleeping,
   output logic return_from_interrupt,
   output logic [3:0] depth
);
   // ****************
   // Sleep and stack
   // ****************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         core_sleeping <= 1'b0;
         return_from_interrupt <= 1'b0;
         depth <= 4'h0;
      end
      else
      begin
         core_sleeping <= sleep_go || (core_sleeping && !wake_req);
         return_from_interrupt <= reti_go;
         // Only the return address is kept; no other context
         depth <= depth + 4'(core_cmd.push_return) - 4'(reti_go);
      end
   end
endmodule : core_model
`default_nettype wire

// File: irq_checker.sv
`timescale 1ns/1ns
`default_nettype none
module irq_checker #(
   parameter int INSTR_DIV = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic core_sleeping,
   input wire logic irq_req,
   input wire logic wake_req,
   input wire irq_logic_pkg::core_cmd_t core_cmd
);
   // Three ticks of dispatch plus tick phase and the command register
   localparam int LAT_MAX = 3 * INSTR_DIV + 2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ****************
   // Properties
   // ****************
   sequence s_vec;
      core_cmd.push_return && core_cmd.vector_addr == 13'h0004 ##1 !core_cmd.vector_take;
   endsequence
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_vec; core_cmd.vector_take |-> s_vec; endproperty
   a_vec: assert property (p_vec) else $error("bad vector entry");
   property p_cause; $rose(core_cmd.vector_take) |-> $past(irq_req) || $past(irq_req, 2); endproperty
   a_cause: assert property (p_cause) else $error("take without request");
   property p_gie_off; core_cmd.vector_take |-> !irq_req; endproperty
   a_gie_off: assert property (p_gie_off) else $error("enable kept on take");
   property p_wake; core_sleeping && irq_req |-> wake_req; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_awake; !core_sleeping |-> !wake_req; endproperty
   a_awake: assert property (p_awake) else $error("wake while awake");
   property p_lat;
      $rose(irq_req) && !core_sleeping
         |-> ##[1:LAT_MAX] (core_cmd.vector_take || !irq_req || core_sleeping);
   endproperty
   a_lat: assert property (p_lat) else $error("take too late");
   property p_rst; $fell(rst) |-> !irq_req && !core_cmd.vector_take; endproperty
   a_rst: assert property (p_rst) else $error("request after reset");
endmodule : irq_checker
bind mcu_interrupt_logic irq_checker #(.INSTR_DIV(INSTR_DIV)) u_chk (.ref_clk, .rst, .cyc_i,
   .stb_i, .ack_o, .core_sleeping, .irq_req, .wake_req, .core_cmd);
`default_nettype wire

// File: irq_logic_pkg.sv
// Notes on behaviour
// - Nine sources: pin, timer, port, six peripherals
// - Flags set regardless of any enable bit
// - Global enable bit 7 gates all requests
// - Enabled flag with global enable requests immediately
// - Any reset clears the global enable
// - Return from interrupt sets global enable again
// - Taking interrupt clears enable, pushes, vectors 0004h
// - Peripheral flags/enables separate, group enable gates
// - Pin, port, timer bits live in control register
// - External events vector within three or four cycles
// - Pin edge chosen by option bit 6
// - Control bit 4 masks the pin flag
// - Enabled pin interrupt wakes from sleep
// - Timer wrap sets bit 2, enable bit 5
// - Port pins 7:4 change sets bit 0
// - Only return address is saved on entry
// - Enabled interrupt wakes regardless of global enable
package irq_logic_pkg;

   // ****************************************
   // Register map (byte offsets on the bus)
   // ****************************************
   localparam logic [4:0] OFS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_PFLAG = 5'h04;
   localparam logic [4:0] OFS_PENABLE = 5'h08;
   localparam logic [4:0] OFS_OPTION = 5'h0C;
   localparam logic [4:0] OFS_STATUS = 5'h10;

   // ****************************************
   // Control register fields and option edge select bit
   // ****************************************
   localparam int B_GLOBAL_EN = 7;
   localparam int B_PERIPH_EN = 6;
   localparam int B_TIMER_EN = 5;
   localparam int B_EXT_EN = 4;
   localparam int B_PORT_EN = 3;
   localparam int B_TIMER_FLAG = 2;
   localparam int B_EXT_FLAG = 1;
   localparam int B_PORT_FLAG = 0;
   localparam int B_EDGE_SEL = 6;

   // Peripheral flag / enable positions
   localparam int P_TIMER2_OVF = 0;
   localparam int P_TIMER3_MATCH = 1;
   localparam int P_CAPTURE = 2;
   localparam int P_SERIAL = 3;
   localparam int P_DISPLAY = 4;
   localparam int P_CONVERTER = 6;
   localparam logic [7:0] PERIPH_MASK = 8'h5F;
   localparam logic [7:0] NO_CONV_MASK = 8'h1F;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] PERIPH_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam int CLKS_PER_INSTR = 4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SYNC = 2'b01,
      ST_TAKE = 2'b11
   } dispatch_st_t;

   typedef struct packed {
      logic vector_take;
      logic push_return;
      logic [12:0] vector_addr;
   } core_cmd_t;

   typedef struct packed {
      logic timer_wrap;
      logic [5:0] periph;
   } src_events_t;

endpackage : irq_logic_pkg

// File: mcu_interrupt_logic.sv
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module mcu_interrupt_logic #(
   parameter bit HAS_CONVERTER = 1'b1,
   parameter int INSTR_DIV = irq_logic_pkg::CLKS_PER_INSTR
) (
   input wire logic ref_clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Sources
   input wire logic ext_irq_pin,
   input wire logic [3:0] port_hi_pins,
   input wire irq_logic_pkg::src_events_t events,
   // Core side
   input wire logic core_sleeping,
   input wire logic return_from_interrupt,
   output logic irq_req,
   output logic wake_req,
   output irq_logic_pkg::core_cmd_t core_cmd
);

   // The divider counter is eight bits wide and needs at least two phases
   if (INSTR_DIV < 2 || INSTR_DIV > 255)
   begin : g_bad_div
      $error("INSTR_DIV out of range");
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] pflag_q, pflag_d;
   logic [7:0] pen_q;
   logic [7:0] option_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [7:0] div_q;
   logic instr_tick;
   irq_logic_pkg::dispatch_st_t st_q;
   irq_logic_pkg::core_cmd_t cmd_q;
   logic ext_edge, port_change;
   logic core_pending, periph_pending;
   logic take;
   logic [7:0] pmask;

   function automatic logic wr_hit(input logic [4:0] ofs);
      wr_hit = cyc_i & stb_i & we_i & ~ack_q & sel_i[0] & (adr_i == ofs);
   endfunction : wr_hit

   assign pmask = HAS_CONVERTER ? irq_logic_pkg::PERIPH_MASK
                                : irq_logic_pkg::NO_CONV_MASK;

   pin_event_detect #(.WIDTH(4)) u_detect (
      .ref_clk(ref_clk),
      .rst(rst),
      .ext_pin(ext_irq_pin),
      .edge_rising(option_q[irq_logic_pkg::B_EDGE_SEL]),
      .port_pins(port_hi_pins),
      .ext_edge(ext_edge),
      .port_change(port_change)
   );

   // ****************************************
   // Instruction-cycle divider
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         div_q <= 8'h00;
      else if (instr_tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end
   assign instr_tick = (div_q == 8'(INSTR_DIV - 1));

   // ****************************************
   // Control register: flags, enables, global enable
   // ****************************************
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_hit(irq_logic_pkg::OFS_CONTROL))
         ctrl_d = dat_i[7:0];
      // Events OR in after the write so a clear never loses one
      ctrl_d[irq_logic_pkg::B_EXT_FLAG] =
         ctrl_d[irq_logic_pkg::B_EXT_FLAG] | ext_edge;
      ctrl_d[irq_logic_pkg::B_TIMER_FLAG] =
         ctrl_d[irq_logic_pkg::B_TIMER_FLAG] | events.timer_wrap;
      ctrl_d[irq_logic_pkg::B_PORT_FLAG] =
         ctrl_d[irq_logic_pkg::B_PORT_FLAG] | port_change;
      if (return_from_interrupt)
         ctrl_d[irq_logic_pkg::B_GLOBAL_EN] = 1'b1;
      if (take)
         ctrl_d[irq_logic_pkg::B_GLOBAL_EN] = 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ctrl_q <= irq_logic_pkg::CONTROL_RST;
      else
         ctrl_q <= ctrl_d;
   end

   // ****************************************
   // Peripheral flag and enable registers, option register
   // ****************************************
   always_comb
   begin
      pflag_d = pflag_q;
      if (wr_hit(irq_logic_pkg::OFS_PFLAG))
         pflag_d = dat_i[7:0];
      pflag_d[irq_logic_pkg::P_TIMER2_OVF] =
         pflag_d[irq_logic_pkg::P_TIMER2_OVF] | events.periph[0];
      pflag_d[irq_logic_pkg::P_TIMER3_MATCH] =
         pflag_d[irq_logic_pkg::P_TIMER3_MATCH] | events.periph[1];
      pflag_d[irq_logic_pkg::P_CAPTURE] = pflag_d[irq_logic_pkg::P_CAPTURE] | events.periph[2];
      pflag_d[irq_logic_pkg::P_SERIAL] = pflag_d[irq_logic_pkg::P_SERIAL] | events.periph[3];
      pflag_d[irq_logic_pkg::P_DISPLAY] = pflag_d[irq_logic_pkg::P_DISPLAY] | events.periph[4];
      pflag_d[irq_logic_pkg::P_CONVERTER] =
         pflag_d[irq_logic_pkg::P_CONVERTER] | events.periph[5];
      pflag_d = pflag_d & pmask;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pflag_q <= irq_logic_pkg::PERIPH_RST;
      else
         pflag_q <= pflag_d;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pen_q <= irq_logic_pkg::PERIPH_RST;
      else if (wr_hit(irq_logic_pkg::OFS_PENABLE))
         pen_q <= dat_i[7:0] & pmask;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         option_q <= irq_logic_pkg::OPTION_RST;
      else if (wr_hit(irq_logic_pkg::OFS_OPTION))
         option_q <= dat_i[7:0];
   end

   // ****************************************
   // Request, wake and dispatch
   // ****************************************
   always_comb
   begin
      core_pending = (ctrl_q[irq_logic_pkg::B_EXT_FLAG] & ctrl_q[irq_logic_pkg::B_EXT_EN])
         | (ctrl_q[irq_logic_pkg::B_TIMER_FLAG] & ctrl_q[irq_logic_pkg::B_TIMER_EN])
         | (ctrl_q[irq_logic_pkg::B_PORT_FLAG] & ctrl_q[irq_logic_pkg::B_PORT_EN]);
      periph_pending = ctrl_q[irq_logic_pkg::B_PERIPH_EN] & (|(pflag_q & pen_q));
      irq_req = ctrl_q[irq_logic_pkg::B_GLOBAL_EN]
         & (core_pending | periph_pending);
      // Wake ignores the global enable; core decides on vectoring after
      wake_req = core_sleeping & (core_pending | periph_pending);
   end

   // Dispatch aligns to instruction boundaries so latency does not
   // depend on the instruction length in progress
   assign take = (st_q == irq_logic_pkg::ST_TAKE) & instr_tick;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         st_q <= irq_logic_pkg::ST_IDLE;
      else if (instr_tick)
      begin
         case (st_q)
            irq_logic_pkg::ST_IDLE:
               if (irq_req && !core_sleeping)
                  st_q <= irq_logic_pkg::ST_SYNC;
            irq_logic_pkg::ST_SYNC:
               st_q <= irq_req ? irq_logic_pkg::ST_TAKE : irq_logic_pkg::ST_IDLE;
            irq_logic_pkg::ST_TAKE:
               st_q <= irq_logic_pkg::ST_IDLE;
            default:
               st_q <= irq_logic_pkg::ST_IDLE;
         endcase
      end
   end

   // Only the return address is pushed; no other context is saved
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cmd_q <= '0;
      else
      begin
         cmd_q.vector_take <= take;
         cmd_q.push_return <= take;
         cmd_q.vector_addr <= irq_logic_pkg::VECTOR_ADDR;
      end
   end
   assign core_cmd = cmd_q;

   // ****************************************
   // Wishbone slave
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ack_q <= 1'b0;
      else
         ack_q <= cyc_i & stb_i & ~ack_q;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= 32'h0000_0000;
      else if (cyc_i && stb_i && !ack_q)
      begin
         case (adr_i)
            irq_logic_pkg::OFS_CONTROL: rdata_q <= {24'h00_0000, ctrl_q};
            irq_logic_pkg::OFS_PFLAG: rdata_q <= {24'h00_0000, pflag_q};
            irq_logic_pkg::OFS_PENABLE: rdata_q <= {24'h00_0000, pen_q};
            irq_logic_pkg::OFS_OPTION: rdata_q <= {24'h00_0000, option_q};
            irq_logic_pkg::OFS_STATUS: rdata_q <= {28'h000_0000, wake_req, irq_req, st_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdata_q;

endmodule : mcu_interrupt_logic
`default_nettype wire

// File: pin_event_detect.sv
`timescale 1ns/1ns
`default_nettype none
module pin_event_detect #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ext_pin,
   input wire logic edge_rising,
   input wire logic [WIDTH-1:0] port_pins,
   output logic ext_edge,
   output logic port_change
);
   logic ext_prev_q;
   logic [WIDTH-1:0] port_prev_q;
   logic primed_q;

   // Primed flag stops a false event on the first edge after reset
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ext_prev_q <= 1'b0;
         port_prev_q <= '0;
         primed_q <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_pin;
         port_prev_q <= port_pins;
         primed_q <= 1'b1;
      end
   end

   always_comb
   begin
      ext_edge = primed_q & (edge_rising ? (ext_pin & ~ext_prev_q)
                                         : (~ext_pin & ext_prev_q));
      port_change = primed_q & (|(port_pins ^ port_prev_q));
   end
endmodule : pin_event_detect
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [31:0] dat_i = 32'h0000_0000;
   logic ext_irq_pin = 1'b0;
   logic [3:0] port_hi_pins = 4'h0;
   irq_logic_pkg::src_events_t events = 7'h00;
   logic sleep_go = 1'b0;
   logic reti_go = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic core_sleeping;
   logic return_from_interrupt;
   logic irq_req;
   logic wake_req;
   irq_logic_pkg::core_cmd_t core_cmd;
   logic [3:0] depth;
   logic [7:0] q;
   int error_cnt = 0;
   int n_compared = 0;
   always #10 ref_clk = ~ref_clk;
   mcu_interrupt_logic dut (.ref_clk, .rst, .cyc_i, .stb_i(cyc_i), .we_i, .adr_i,
      .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .ext_irq_pin, .port_hi_pins, .events,
      .core_sleeping, .return_from_interrupt, .irq_req, .wake_req, .core_cmd);
   core_model u_core (.ref_clk, .rst, .core_cmd, .wake_req, .sleep_go, .reti_go,
      .core_sleeping, .return_from_interrupt, .depth);
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // A source pulse rides along with the request so it can meet a write
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
      input logic [6:0] e);
      int k;
      k = 0;
      @(posedge ref_clk);
      cyc_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      events <= e;
      do
      begin
         @(posedge ref_clk);
         events <= 7'h00;
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (k == 20)
         error_cnt++;
      q = dat_o[7:0];
      cyc_i <= 1'b0;
   endtask : wb
   task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00, 7'h00);
      chk(q, exp);
   endtask : rdc
   task automatic wait_depth(input logic [3:0] exp);
      for (int k = 0; k < 16 && depth !== exp; k++)
         @(posedge ref_clk);
      chk(8'(depth), 8'(exp));
   endtask : wait_depth
   task automatic pulse_core(input logic s);
      @(posedge ref_clk);
      sleep_go <= s;
      reti_go <= !s;
      @(posedge ref_clk);
      sleep_go <= 1'b0;
      reti_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : pulse_core
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      #100000;
      error_cnt++;
      close_out();
   end
   // ****************
   // Tests
   // ****************
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rdc(5'h00, 8'h00);
      rdc(5'h0C, 8'hFF);
      rdc(5'h14, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 7; i++)
         wb(1'b0, 5'h14, 8'h00, 7'(1 << i));
      ext_irq_pin <= 1'b1;
      port_hi_pins <= 4'h9;
      repeat (4) @(posedge ref_clk);
      rdc(5'h04, 8'h5F);
      rdc(5'h00, 8'h07);
      chk(8'(irq_req), 8'h00);
      $display("test flags done");
      wb(1'b1, 5'h0C, 8'hBF, 7'h00);
      wb(1'b1, 5'h00, 8'h00, 7'h40);
      ext_irq_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdc(5'h00, 8'h06);
      $display("test edge done");
      wb(1'b1, 5'h00, 8'h82, 7'h00);
      chk(8'(irq_req), 8'h00);
      wb(1'b1, 5'h00, 8'h92, 7'h00);
      chk(8'(irq_req), 8'h01);
      wait_depth(4'h1);
      rdc(5'h00, 8'h12);
      wb(1'b1, 5'h00, 8'h10, 7'h00);
      pulse_core(1'b0);
      rdc(5'h00, 8'h90);
      chk(8'(irq_req), 8'h00);
      $display("test take done");
      wb(1'b1, 5'h08, 8'h08, 7'h00);
      wb(1'b1, 5'h04, 8'h08, 7'h00);
      chk(8'(irq_req), 8'h00);
      wb(1'b1, 5'h00, 8'hC0, 7'h00);
      wait_depth(4'h1);
      wb(1'b1, 5'h04, 8'h00, 7'h00);
      pulse_core(1'b0);
      $display("test group done");
      wb(1'b1, 5'h00, 8'hA0, 7'h00);
      pulse_core(1'b1);
      chk(8'(core_sleeping), 8'h01);
      wb(1'b0, 5'h14, 8'h00, 7'h40);
      repeat (2) @(posedge ref_clk);
      chk(8'(core_sleeping), 8'h00);
      wait_depth(4'h1);
      $display("test sleep done");
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      rdc(5'h00, 8'h00);
      $display("test reset again done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
